// [hw/cipr_pkg.sv]
package cipr_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] CIPR_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] CIPR_ADDR_STATUS = 4'h1;
  localparam logic [3:0] CIPR_ADDR_PRI    = 4'h2;
  localparam logic [3:0] CIPR_ADDR_L1VEC  = 4'h3;
  localparam logic [3:0] CIPR_ADDR_ACKVEC = 4'h4;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CIPR_CTRL_RR_BIT    = 0;
  localparam int CIPR_CTRL_CVT_BIT   = 5;
  localparam int CIPR_CTRL_VECTOR_LOCATION_SELECT_BIT = 6;
  localparam int CIPR_ST_L0_BIT      = 0;
  localparam int CIPR_ST_L1_BIT      = 1;
  localparam int CIPR_ST_NMI_BIT     = 7;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] CIPR_CTRL_RST   = 8'h00;
  localparam logic [7:0] CIPR_PRI_RST    = 8'h00;
  localparam logic [7:0] CIPR_L1VEC_RST  = 8'h00;

  // ****************************************************************
  // vector addressing
  // ****************************************************************
  localparam logic [7:0] CIPR_CVT_NMI_ADDR = 8'h01;
  localparam logic [7:0] CIPR_CVT_L1_ADDR  = 8'h02;
  localparam logic [7:0] CIPR_CVT_L0_ADDR  = 8'h03;
  localparam logic [7:0] CIPR_VEC_OFS      = 8'h01;

  // ****************************************************************
  // sequencing
  // ****************************************************************
  typedef enum logic [1:0] {
    CIPR_IDLE = 2'b00,
    CIPR_ACK  = 2'b01,
    CIPR_HOLD = 2'b10
  } cipr_state_t;

endpackage

// [hw/cipr_arbiter.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// rotating lowest-index-first picker
// ****************************************************************
module cipr_arbiter #(
  parameter int N  = 16,
  parameter int VW = 4
) (
  input  wire logic [N-1:0]  req_i,
  input  wire logic [VW-1:0] last_i,
  input  wire logic          rotate_i,
  output logic               hit_o,
  output logic [VW-1:0]      idx_o
);

  logic [VW-1:0] start;
  logic [VW-1:0] cand;
  logic [VW:0]   sum;
  int            k;

  always_comb begin
    start = '0;
    cand  = '0;
    sum   = '0;
    hit_o = 1'b0;
    idx_o = '0;
    if (rotate_i) begin
      sum   = {1'b0, last_i} + (VW+1)'(1);
      start = (sum >= (VW+1)'(N)) ? '0 : sum[VW-1:0];
    end
    for (k = N - 1; k >= 0; k--) begin
      sum  = {1'b0, start} + (VW+1)'(k);
      cand = (sum >= (VW+1)'(N)) ? VW'(sum - (VW+1)'(N)) : sum[VW-1:0];
      if (req_i[cand]) begin
        hit_o = 1'b1;
        idx_o = cand;
      end
    end
  end

endmodule
`default_nettype wire

// [hw/cipr_status.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// executing-level flags
// ****************************************************************
module cipr_status (
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  input  wire logic run_i,
  input  wire logic set_l0_i,
  input  wire logic set_l1_i,
  input  wire logic set_nmi_i,
  input  wire logic interrupt_return_instruction_i,
  output logic      l0_o,
  output logic      l1_o,
  output logic      nmi_o
);

  logic l0_r, l0_nxt;
  logic l1_r, l1_nxt;
  logic nmi_r, nmi_nxt;

  always_comb begin
    l0_nxt  = l0_r;
    l1_nxt  = l1_r;
    nmi_nxt = nmi_r;
    if (run_i) begin
      // highest active level leaves first
      if (interrupt_return_instruction_i) begin
        if (nmi_r) begin
          nmi_nxt = 1'b0;
        end else if (l1_r) begin
          l1_nxt = 1'b0;
        end else begin
          l0_nxt = 1'b0;
        end
      end
      if (set_l0_i) begin
        l0_nxt = 1'b1;
      end
      if (set_l1_i) begin
        l1_nxt = 1'b1;
      end
      if (set_nmi_i) begin
        nmi_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      l0_r  <= 1'b0;
      l1_r  <= 1'b0;
      nmi_r <= 1'b0;
    end else begin
      l0_r  <= l0_nxt;
      l1_r  <= l1_nxt;
      nmi_r <= nmi_nxt;
    end
  end

  assign l0_o  = l0_r;
  assign l1_o  = l1_r;
  assign nmi_o = nmi_r;

endmodule
`default_nettype wire

// [hw/cipr_top.sv]
// Behaviour
// - take enabled requests; acknowledge or hold by level against running handler
// - on acknowledge drive the request's vector address to the core
// - one instruction retires before any pending request is served
// - status flags track executing level for interrupt return
// - interrupt return restores state held before the left handler
// - status is never saved automatically on acknowledge
// - after reset every vector is normal priority level 0
// - at most one vector, never vector 0, may be raised to level 1
// - level 1 request preempts running level 0 handler
// - static ordering grants lowest pending level 0 vector first
// - optional round-robin ordering for level 0 requests
// - maskable requests only while global enable is set
// - global enable is never changed by acknowledge
// - vector table in application or boot section by select bit
// - runs in run-time debug, halts while core halted
// - clocked from the peripheral clock
// - non-maskable ignores enable, not preempted, lowest vector first
// - priority pointer vector is lowest, next is highest, wraps, resets zero; pointer zero without round-robin leaves vector 0 highest
// - round-robin loads pointer with each acknowledged level 0 vector
// - compact table uses addresses 1, 2 and 3
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module cipr_top
  import cipr_pkg::*;
#(
  parameter int         NVEC     = 16,
  parameter int         VW       = 4,
  parameter logic [7:0] BOOT_BASE = 8'h80
) (
  input  wire logic            ref_clk_i,
  input  wire logic            nrst_i,
  input  wire logic [NVEC-1:0] irq_i,
  input  wire logic [NVEC-1:0] nmi_mask_i,
  input  wire logic            gie_i,
  input  wire logic            insn_done_i,
  input  wire logic            interrupt_return_instruction_i,
  input  wire logic            dbg_halt_i,
  input  wire logic [3:0]      addr_i,
  input  wire logic [7:0]      wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output logic [7:0]           rdata_o,
  output logic                 ack_o,
  output logic [7:0]           vec_addr_o,
  output logic [VW-1:0]        ack_idx_o,
  output logic                 lvl0_o,
  output logic                 lvl1_o,
  output logic                 nmi_o
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]    ctrl_r, ctrl_nxt;
  logic [VW-1:0] pri_r, pri_nxt;
  logic [VW-1:0] l1vec_r, l1vec_nxt;
  logic [VW-1:0] lastack_r, lastack_nxt;
  logic [7:0]    rdata_r, rdata_nxt;
  logic          ack_r, ack_nxt;
  logic [7:0]    vaddr_r, vaddr_nxt;
  logic          ok_r, ok_nxt;
  cipr_state_t   st_r, st_nxt;
  logic          run;
  logic          st_l0, st_l1, st_nmi;

  assign run = !dbg_halt_i;

  // ****************************************************************
  // request classes
  // ****************************************************************
  logic [NVEC-1:0] l1_onehot;
  logic [NVEC-1:0] nmi_req;
  logic [NVEC-1:0] l1_req;
  logic [NVEC-1:0] l0_req;
  logic            nmi_hit, l1_hit, l0_hit;
  logic [VW-1:0]   nmi_idx, l1_idx, l0_idx;

  // index 0 selects no level 1 line, so reset leaves every vector at level 0
  always_comb begin
    l1_onehot = '0;
    l1_onehot[l1vec_r] = (l1vec_r != '0);
  end

  assign nmi_req = irq_i & nmi_mask_i;
  assign l1_req  = irq_i & ~nmi_mask_i & l1_onehot & {NVEC{gie_i}};
  assign l0_req  = irq_i & ~nmi_mask_i & ~l1_onehot & {NVEC{gie_i}};

  cipr_arbiter #(.N(NVEC), .VW(VW)) u_nmi_arb (
    .req_i    (nmi_req),
    .last_i   ('0),
    .rotate_i (1'b0),
    .hit_o    (nmi_hit),
    .idx_o    (nmi_idx)
  );

  cipr_arbiter #(.N(NVEC), .VW(VW)) u_l1_arb (
    .req_i    (l1_req),
    .last_i   ('0),
    .rotate_i (1'b0),
    .hit_o    (l1_hit),
    .idx_o    (l1_idx)
  );

  // nonzero pointer, or any pointer under round-robin, ranks lowest, next ranks highest
  cipr_arbiter #(.N(NVEC), .VW(VW)) u_l0_arb (
    .req_i    (l0_req),
    .last_i   (pri_r),
    .rotate_i (pri_r != '0 || ctrl_r[CIPR_CTRL_RR_BIT]),
    .hit_o    (l0_hit),
    .idx_o    (l0_idx)
  );

  // ****************************************************************
  // grant decision
  // ****************************************************************
  logic          go_nmi, go_l1, go_l0, grant;
  logic [VW-1:0] gidx;
  logic [7:0]    vbase;

  always_comb begin
    go_nmi = nmi_hit && !st_nmi;
    go_l1  = !go_nmi && l1_hit && !st_nmi && !st_l1;
    go_l0  = !go_nmi && !go_l1 && l0_hit && !st_nmi && !st_l1 && !st_l0;
    grant  = (go_nmi || go_l1 || go_l0) && ok_r && (st_r == CIPR_IDLE) && run;
    gidx   = go_nmi ? nmi_idx : (go_l1 ? l1_idx : l0_idx);
    vbase  = ctrl_r[CIPR_CTRL_VECTOR_LOCATION_SELECT_BIT] ? BOOT_BASE : 8'h00;
  end

  // ****************************************************************
  // sequencer and register file
  // ****************************************************************
  always_comb begin
    ctrl_nxt    = ctrl_r;
    pri_nxt     = pri_r;
    l1vec_nxt   = l1vec_r;
    lastack_nxt = lastack_r;
    rdata_nxt   = 8'h00;
    ack_nxt     = 1'b0;
    vaddr_nxt   = vaddr_r;
    ok_nxt      = ok_r;
    st_nxt      = st_r;
    if (run) begin
      // one retired instruction re-arms service
      if (insn_done_i) begin
        ok_nxt = 1'b1;
      end
      if (interrupt_return_instruction_i) begin
        ok_nxt = 1'b0;
      end
      unique case (st_r)
        CIPR_IDLE: begin
          if (grant) begin
            st_nxt      = CIPR_ACK;
            ack_nxt     = 1'b1;
            ok_nxt      = 1'b0;
            lastack_nxt = gidx;
            if (ctrl_r[CIPR_CTRL_CVT_BIT]) begin
              vaddr_nxt = vbase + (go_nmi ? CIPR_CVT_NMI_ADDR :
                          (go_l1 ? CIPR_CVT_L1_ADDR : CIPR_CVT_L0_ADDR));
            end else begin
              vaddr_nxt = vbase + CIPR_VEC_OFS + 8'(gidx);
            end
            if (go_l0 && ctrl_r[CIPR_CTRL_RR_BIT]) begin
              pri_nxt = gidx;
            end
          end
        end
        CIPR_ACK: begin
          st_nxt = CIPR_HOLD;
        end
        CIPR_HOLD: begin
          st_nxt = CIPR_IDLE;
        end
        default: begin
          st_nxt = CIPR_IDLE;
        end
      endcase
    end
    if (wr_i) begin
      unique case (addr_i)
        CIPR_ADDR_CTRL:  ctrl_nxt  = wdata_i;
        CIPR_ADDR_PRI:   pri_nxt   = wdata_i[VW-1:0];
        CIPR_ADDR_L1VEC: l1vec_nxt = wdata_i[VW-1:0];
        default: ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        CIPR_ADDR_CTRL:   rdata_nxt = ctrl_r;
        CIPR_ADDR_STATUS: rdata_nxt = {st_nmi, 5'h00, st_l1, st_l0};
        CIPR_ADDR_PRI:    rdata_nxt = 8'(pri_r);
        CIPR_ADDR_L1VEC:  rdata_nxt = 8'(l1vec_r);
        CIPR_ADDR_ACKVEC: rdata_nxt = 8'(lastack_r);
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      ctrl_r    <= CIPR_CTRL_RST;
      pri_r     <= VW'(CIPR_PRI_RST);
      l1vec_r   <= VW'(CIPR_L1VEC_RST);
      lastack_r <= '0;
      rdata_r   <= 8'h00;
      ack_r     <= 1'b0;
      vaddr_r   <= 8'h00;
      ok_r      <= 1'b0;
      st_r      <= CIPR_IDLE;
    end else begin
      ctrl_r    <= ctrl_nxt;
      pri_r     <= pri_nxt;
      l1vec_r   <= l1vec_nxt;
      lastack_r <= lastack_nxt;
      rdata_r   <= rdata_nxt;
      ack_r     <= ack_nxt;
      vaddr_r   <= vaddr_nxt;
      ok_r      <= ok_nxt;
      st_r      <= st_nxt;
    end
  end

  // status flags change only on acknowledge or return, never saved
  cipr_status u_status (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .run_i     (run),
    .set_l0_i  (grant && go_l0),
    .set_l1_i  (grant && go_l1),
    .set_nmi_i (grant && go_nmi),
    .interrupt_return_instruction_i    (interrupt_return_instruction_i),
    .l0_o      (st_l0),
    .l1_o      (st_l1),
    .nmi_o     (st_nmi)
  );

  assign rdata_o    = rdata_r;
  assign ack_o      = ack_r;
  assign vec_addr_o = vaddr_r;
  assign ack_idx_o  = lastack_r;
  assign lvl0_o     = st_l0;
  assign lvl1_o     = st_l1;
  assign nmi_o      = st_nmi;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  ack_needs_ok_a: assert property (ack_nxt |-> ok_r && st_r == CIPR_IDLE)
    else $error("ack without retired instruction");
  ack_gap_a: assert property (ack_o |=> !ack_o ##1 !ack_o)
    else $error("acknowledges too close");
  mask_gie_a: assert property (ack_nxt && !go_nmi |-> gie_i)
    else $error("maskable ack with enable clear");
  l1_pre_a: assert property (grant && go_l1 |=> lvl1_o)
    else $error("level 1 flag not set");
  nmi_block_a: assert property (nmi_o && !interrupt_return_instruction_i |=> !ack_o)
    else $error("nmi handler preempted");
  rr_load_a: assert property (grant && go_l0 && ctrl_r[CIPR_CTRL_RR_BIT]
                              |=> pri_r == $past(gidx))
    else $error("pointer not loaded");
  cvt_l0_a: assert property (grant && go_l0 && ctrl_r[CIPR_CTRL_CVT_BIT]
                             && !ctrl_r[CIPR_CTRL_VECTOR_LOCATION_SELECT_BIT]
                             |=> vec_addr_o == CIPR_CVT_L0_ADDR)
    else $error("compact level 0 address wrong");
  halt_a: assert property (dbg_halt_i |=> !ack_o)
    else $error("ack while halted");
  interrupt_return_instruction_a: assert property (interrupt_return_instruction_i && run && nmi_o |=> !nmi_o)
    else $error("return left nmi flag");
  interrupt_return_instruction_ok_a: assert property (interrupt_return_instruction_i && run |=> !ok_r)
    else $error("return did not re-arm the gap");
  l0_block_a: assert property (lvl0_o && !interrupt_return_instruction_i |-> !(grant && go_l0))
    else $error("level 0 nested in level 0");
  l0_static_a: assert property (grant && go_l0 && !ctrl_r[CIPR_CTRL_RR_BIT]
                                && pri_r == '0
                                |-> (l0_req & ((NVEC'(1) << gidx) - NVEC'(1))) == '0)
    else $error("lower pending level 0 skipped");
  nmi_low_a: assert property (grant && go_nmi
                              |-> (nmi_req & ((NVEC'(1) << nmi_idx) - NVEC'(1))) == '0)
    else $error("higher nmi line skipped");
  vec_norm_a: assert property (grant && !ctrl_r[CIPR_CTRL_CVT_BIT]
                               |=> vec_addr_o == $past(vbase + CIPR_VEC_OFS + 8'(gidx)))
    else $error("vector address wrong");
  ret_lvl_a: assert property (interrupt_return_instruction_i && run && !nmi_o && lvl1_o && !grant
                              |=> !lvl1_o && lvl0_o == $past(lvl0_o))
    else $error("return left wrong level");
  halt_hold_a: assert property (dbg_halt_i |=> lvl0_o == $past(lvl0_o)
                                && lvl1_o == $past(lvl1_o) && nmi_o == $past(nmi_o))
    else $error("flags moved while halted");

  cov_nmi_c:  cover property (grant && go_nmi);
  cov_pre_c:  cover property (lvl0_o && grant && go_l1);
  cov_rr_c:   cover property (grant && go_l0 && ctrl_r[CIPR_CTRL_RR_BIT]);
  cov_cvt_c:  cover property (grant && ctrl_r[CIPR_CTRL_CVT_BIT]);
  cov_halt_c: cover property (dbg_halt_i && l0_hit);

endmodule
`default_nettype wire

// [test/cipr_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// core side: retires instructions, runs handlers, returns
// ****************************************************************
module cipr_core_model (
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  input  wire logic ack_i,
  input  wire logic stall_i,
  input  wire logic halt_i,
  output wire logic insn_done_o,
  output logic      interrupt_return_instruction_o
);
  logic [1:0] phase_r;

  // handler entry costs cycles before the next instruction retires
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      phase_r <= 2'h0;
    end else if (ack_i) begin
      phase_r <= 2'h0;
    end else if (!halt_i) begin
      phase_r <= phase_r + 2'h1;
    end
  end

  assign insn_done_o = nrst_i && !stall_i && !halt_i && (phase_r == 2'h3);

  initial interrupt_return_instruction_o = 1'b0;

  task automatic do_interrupt_return_instruction();
    @(posedge ref_clk_i) interrupt_return_instruction_o <= 1'b1;
    @(posedge ref_clk_i) interrupt_return_instruction_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/cpu_interrupt_prioritizer_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module cpu_interrupt_prioritizer_bench;
  import cipr_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [15:0] irq = 16'h0000;
  logic [15:0] nmi_mask = 16'h0000;
  logic        gie = 1'b0;
  logic        stall = 1'b0;
  logic        halt = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata_o;
  logic        ack_o;
  logic [7:0]  vec_addr_o;
  logic [3:0]  ack_idx_o;
  logic        lvl0_o;
  logic        lvl1_o;
  logic        nmi_o;
  wire logic   insn_done;
  logic        interrupt_return_instruction;
  int          err_count = 0;
  int          checked = 0;
  int          cyc = 0;

  always #25 ref_clk_i = ~ref_clk_i;

  cipr_top dut (
    .ref_clk_i  (ref_clk_i),
    .nrst_i     (nrst_i),
    .irq_i      (irq),
    .nmi_mask_i (nmi_mask),
    .gie_i      (gie),
    .insn_done_i(insn_done),
    .interrupt_return_instruction_i     (interrupt_return_instruction),
    .dbg_halt_i (halt),
    .addr_i     (addr),
    .wdata_i    (wdata),
    .wr_i       (wr),
    .rd_i       (rd),
    .rdata_o    (rdata_o),
    .ack_o      (ack_o),
    .vec_addr_o (vec_addr_o),
    .ack_idx_o  (ack_idx_o),
    .lvl0_o     (lvl0_o),
    .lvl1_o     (lvl1_o),
    .nmi_o      (nmi_o)
  );

  cipr_core_model core (
    .ref_clk_i  (ref_clk_i),
    .nrst_i     (nrst_i),
    .ack_i      (ack_o),
    .stall_i    (stall),
    .halt_i     (halt),
    .insn_done_o(insn_done),
    .interrupt_return_instruction_o     (interrupt_return_instruction)
  );

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic tally_and_finish();
    if (err_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge ref_clk_i) wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk_i) begin addr <= a; rd <= 1'b1; end
    @(posedge ref_clk_i) rd <= 1'b0;
    #1 `CHK(rdata_o, e)
  endtask

  task automatic irq_on(input logic [15:0] m);
    @(posedge ref_clk_i) irq <= irq | m;
  endtask

  // handler clears its source once entered
  task automatic wait_ack(input logic [7:0] v, input logic [3:0] i);
    int n;
    n = 0;
    do begin @(posedge ref_clk_i); #1; n++; end while (ack_o !== 1'b1 && n < 60);
    `CHK(ack_o, 1'b1)
    `CHK(vec_addr_o, v)
    `CHK(ack_idx_o, i)
    @(posedge ref_clk_i) irq[i] <= 1'b0;
  endtask

  task automatic no_ack(input int n);
    repeat (n) begin @(posedge ref_clk_i); #1; `CHK(ack_o, 1'b0) end
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    for (int a = 0; a < 6; a++) rreg(4'(a), 8'h00);
    wreg(4'h5, 8'hff);
    rreg(4'h5, 8'h00);
    wreg(CIPR_ADDR_L1VEC, 8'h0f);
    rreg(CIPR_ADDR_L1VEC, 8'h0f);
    irq_on(16'h0008);
    no_ack(10);
    @(posedge ref_clk_i) gie <= 1'b1;
    wait_ack(8'h04, 4'h3);
    `CHK(lvl0_o, 1'b1)
    rreg(CIPR_ADDR_STATUS, 8'h01);
    wreg(CIPR_ADDR_L1VEC, 8'h09);
    irq_on(16'h0200);
    wait_ack(8'h0a, 4'h9);
    `CHK(lvl1_o, 1'b1)
    rreg(CIPR_ADDR_STATUS, 8'h03);
    core.do_interrupt_return_instruction();
    rreg(CIPR_ADDR_STATUS, 8'h01);
    core.do_interrupt_return_instruction();
    rreg(CIPR_ADDR_STATUS, 8'h00);
    irq_on(16'h0024);
    wait_ack(8'h03, 4'h2);
    no_ack(8);
    @(posedge ref_clk_i) stall <= 1'b1;
    core.do_interrupt_return_instruction();
    no_ack(12);
    @(posedge ref_clk_i) stall <= 1'b0;
    wait_ack(8'h06, 4'h5);
    core.do_interrupt_return_instruction();
    wreg(CIPR_ADDR_PRI, 8'h04);
    irq_on(16'h0024);
    wait_ack(8'h06, 4'h5);
    core.do_interrupt_return_instruction();
    wait_ack(8'h03, 4'h2);
    core.do_interrupt_return_instruction();
    wreg(CIPR_ADDR_PRI, 8'h00);
    wreg(CIPR_ADDR_CTRL, 8'h01);
    irq_on(16'h0012);
    wait_ack(8'h02, 4'h1);
    rreg(CIPR_ADDR_PRI, 8'h01);
    irq_on(16'h0002);
    core.do_interrupt_return_instruction();
    wait_ack(8'h05, 4'h4);
    rreg(CIPR_ADDR_PRI, 8'h04);
    core.do_interrupt_return_instruction();
    wait_ack(8'h02, 4'h1);
    core.do_interrupt_return_instruction();
    wreg(CIPR_ADDR_CTRL, 8'h00);
    @(posedge ref_clk_i) begin gie <= 1'b0; nmi_mask <= 16'h00c0; end
    irq_on(16'h00c0);
    wait_ack(8'h07, 4'h6);
    `CHK(nmi_o, 1'b1)
    irq_on(16'h0200);
    no_ack(10);
    core.do_interrupt_return_instruction();
    wait_ack(8'h08, 4'h7);
    core.do_interrupt_return_instruction();
    no_ack(8);
    @(posedge ref_clk_i) begin gie <= 1'b1; nmi_mask <= 16'h0000; end
    wait_ack(8'h0a, 4'h9);
    core.do_interrupt_return_instruction();
    wreg(CIPR_ADDR_CTRL, 8'h20);
    irq_on(16'h0008);
    wait_ack(CIPR_CVT_L0_ADDR, 4'h3);
    irq_on(16'h0200);
    wait_ack(CIPR_CVT_L1_ADDR, 4'h9);
    core.do_interrupt_return_instruction();
    core.do_interrupt_return_instruction();
    wreg(CIPR_ADDR_CTRL, 8'h40);
    @(posedge ref_clk_i) halt <= 1'b1;
    irq_on(16'h0008);
    no_ack(10);
    @(posedge ref_clk_i) halt <= 1'b0;
    wait_ack(8'h84, 4'h3);
    core.do_interrupt_return_instruction();
    rreg(CIPR_ADDR_STATUS, 8'h00);
    @(posedge ref_clk_i) nrst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rreg(CIPR_ADDR_CTRL, 8'h00);
    rreg(CIPR_ADDR_L1VEC, 8'h00);
    irq_on(16'h0002);
    wait_ack(8'h02, 4'h1);
    irq_on(16'h0001);
    no_ack(8);
    core.do_interrupt_return_instruction();
    wait_ack(8'h01, 4'h0);
    core.do_interrupt_return_instruction();
    rreg(CIPR_ADDR_STATUS, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
